// [hbp_defs.svh]
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// ==========================================
// register port framing
`define HBP_AW 6
`define HBP_WR_BIT 7
`define HBP_BITS_PER_BYTE 4'h7

// ==========================================
// register offsets
`define HBP_ADDR_SWITCHES 6'h01
`define HBP_ADDR_CTRL 6'h02
`define HBP_ADDR_SYS 6'h03
`define HBP_ADDR_FLAGS 6'h05
`define HBP_ADDR_RSTMASK 6'h06
`define HBP_ADDR_SUPPLY 6'h0B
`define HBP_ADDR_STATUS 6'h0C

// ==========================================
// field positions and reset values
`define HBP_RST_BYTE 8'h00
`define HBP_CTRL_MASK 8'hC7
`define HBP_BIT_OFC 7
`define HBP_BIT_GAIN 6
`define HBP_LIM_HI 2
`define HBP_BIT_PSTAGE 7
`define HBP_BIT_SUP_ON 1
`define HBP_BIT_HTRE 0
`define HBP_FLG_HT 4
`define HBP_FLG_LV 3
`define HBP_FLG_HV 2
`define HBP_ST_LV 3
`define HBP_ST_HV 2
`define HBP_ST_OC 1
`define HBP_ST_HT 0
`define HBP_LIM_MIN 3'h3

// ==========================================
// timing
`define HBP_CLK_NS 40
`define HBP_BBM_NS 200
`define HBP_BBM_CYC ((`HBP_BBM_NS + `HBP_CLK_NS - 1) / `HBP_CLK_NS)
`define HBP_BBM_W 3
`define HBP_NPIN 18

`endif

// [hbp_pkg.sv]
`include "hbp_defs.svh"

package hbp_pkg;

  // ==========================================
  // register port sequencer
  typedef enum logic [1:0] {
    HBP_SPI_IDLE,
    HBP_SPI_ADDR,
    HBP_SPI_DATA,
    HBP_SPI_DONE
  } hbp_spi_st_t;

  // ==========================================
  // state of one half-bridge driver
  typedef struct packed {
    logic hs;
    logic ls;
    logic cut;
    logic [`HBP_BBM_W-1:0] cnt;
  } hbp_br_t;

  // ==========================================
  // state of the control block
  typedef struct packed {
    logic [`HBP_NPIN-1:0] s1;
    logic [`HBP_NPIN-1:0] s2;
    logic [`HBP_NPIN-1:0] s3;
    logic [`HBP_NPIN-1:0] f;
    logic sck_d;
    logic cs_d;
    logic chopping_frequency_input_d;
    hbp_spi_st_t st;
    logic [3:0] bitc;
    logic [7:0] rx;
    logic [`HBP_AW-1:0] addr;
    logic wr;
    logic [7:0] tx;
    logic oe;
    logic [7:0] sw;
    logic [7:0] ctrl;
    logic pstage;
    logic sup_on;
    logic htre;
    logic ht;
    logic lv;
    logic hv;
    logic hs_trip;
    logic ls_trip;
    logic therm;
    logic sup_pin;
    logic recirc;
    logic lim_en;
    logic rearm_lo;
    logic rearm_hi;
    logic [3:0] req_hs;
    logic [3:0] req_ls;
  } hbp_main_t;

endpackage

// [hbp_chan_if.sv]
`timescale 1ns/100ps

interface hbp_chan_if;
  logic req_hs;
  logic req_ls;
  logic rearm;
  logic lim_en;
  logic over_lim;
  logic hs_on;
  logic ls_on;

  modport ctrl (output req_hs, output req_ls, output rearm, output lim_en,
    output over_lim, input hs_on, input ls_on);
  modport drv (input req_hs, input req_ls, input rearm, input lim_en,
    input over_lim, output hs_on, output ls_on);
endinterface

// [hbp_bridge.sv]
`timescale 1ns/100ps
`include "hbp_defs.svh"

module hbp_bridge
  import hbp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  hbp_chan_if.drv ch
);

  // ==========================================
  // state
  hbp_br_t st_r;
  hbp_br_t st_nxt;
  logic want_hs;
  logic want_ls;

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    want_hs = ch.req_hs;
    want_ls = ch.req_ls & ~ch.req_hs & ~st_r.cut;
    if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - `HBP_BBM_W'(1);
    end
    if (ch.rearm) begin
      st_nxt.cut = 1'b0;
    end
    if (st_r.ls & ch.lim_en & ch.over_lim) begin
      st_nxt.cut = 1'b1;
    end
    if (st_r.hs & ~want_hs) begin
      st_nxt.hs = 1'b0;
      st_nxt.cnt = `HBP_BBM_W'(`HBP_BBM_CYC);
    end
    if (st_r.ls & (~want_ls | st_nxt.cut)) begin
      st_nxt.ls = 1'b0;
      st_nxt.cnt = `HBP_BBM_W'(`HBP_BBM_CYC);
    end
    if (want_hs & ~st_r.hs & ~st_r.ls & (st_r.cnt == '0)) begin
      st_nxt.hs = 1'b1;
    end else if (want_ls & ~st_nxt.cut & ~st_r.ls & ~st_r.hs & (st_r.cnt == '0)) begin
      st_nxt.ls = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ch.hs_on = st_r.hs;
  assign ch.ls_on = st_r.ls;

endmodule

// [hbp_stage_ctrl.sv]
// Function
// - supply output follows supply-on bit, reset clears
// - reset clears all half-bridge switch bits
// - no bridge drive without power-stages-on bit
// - both bits set: only high side on
// - low-side bits 6,4,2,0 switch low sides
// - high-side bits 7,5,3,1 switch high sides
// - over-limit low side switches off, stays off
// - chopping input rising edge re-arms low side
// - offset chopping: bridges 3,4 re-arm on falling
// - gain bit 6 selects sense range
// - recirculation output high while any bridge recirculates
// - temperature warning flag; enabled limit trips reset
// - high-side overcurrent: all high sides off, flag
// - low-side overcurrent: all low sides off, flag
// - writing one clears overcurrent flag, re-enables
// - voltage flags set keep bridges disabled
// - write-one clears voltage flag unless fault persists
// - control register layout, bits 5..3 read zero
// - limit codes 0..2 none, 3..7 limits
// - supply needs stages-on and supply-on, ignores voltage
// - supply thermal cutoff only when reset enabled
// - stages-on is system-control bit 7, reset clears
`timescale 1ns/100ps
`include "hbp_defs.svh"

module hbp_stage_ctrl
  import hbp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire logic chopping_frequency_input_in,
  input wire logic hs_overcurrent_in,
  input wire logic ls_overcurrent_in,
  input wire logic [3:0] ls_over_limit_in,
  input wire logic [3:0] recirc_sense_in,
  input wire logic voltage_low_in,
  input wire logic voltage_high_in,
  input wire logic temp_warn_in,
  input wire logic temp_limit_in,
  output logic [3:0] high_side_on_out,
  output logic [3:0] low_side_on_out,
  output logic switched_supply_pin_out,
  output logic recirculation_detect_out,
  output logic sense_gain_select_out,
  output logic [2:0] current_limit_select_out,
  output logic limit_active_out,
  output logic reset_request_out
);

  // ==========================================
  // state and filtered pins
  hbp_main_t st_r;
  hbp_main_t st_nxt;
  logic [`HBP_NPIN-1:0] pins;
  logic [3:0] lim_f;
  logic [3:0] rc_f;
  logic sck_f;
  logic cs_f;
  logic mosi_f;
  logic chopping_frequency_input_f;
  logic hsoc_f;
  logic lsoc_f;
  logic lv_f;
  logic hv_f;
  logic ht_f;
  logic tl_f;
  logic [7:0] wdat;
  logic wr_go;
  logic en_all;
  logic rise;
  logic fall;

  assign pins = {temp_limit_in, temp_warn_in, voltage_high_in, voltage_low_in,
    ls_overcurrent_in, hs_overcurrent_in, chopping_frequency_input_in,
    spi_mosi_in, spi_cs_n_in, spi_sck_in, recirc_sense_in, ls_over_limit_in};
  assign {tl_f, ht_f, hv_f, lv_f, lsoc_f, hsoc_f, chopping_frequency_input_f, mosi_f, cs_f, sck_f,
    rc_f, lim_f} = st_r.f;

  // ==========================================
  // register read
  function automatic logic [7:0] rd_reg(input hbp_main_t r, input logic [`HBP_AW-1:0] a);
    logic [7:0] d;
    d = `HBP_RST_BYTE;
    case (a)
      `HBP_ADDR_SWITCHES: d = r.sw;
      `HBP_ADDR_CTRL: d = r.ctrl & `HBP_CTRL_MASK;
      `HBP_ADDR_SYS: d[`HBP_BIT_PSTAGE] = r.pstage;
      `HBP_ADDR_FLAGS: begin
        d[`HBP_FLG_HT] = r.ht;
        d[`HBP_FLG_LV] = r.lv;
        d[`HBP_FLG_HV] = r.hv;
      end
      `HBP_ADDR_RSTMASK: d[`HBP_BIT_HTRE] = r.htre;
      `HBP_ADDR_SUPPLY: d[`HBP_BIT_SUP_ON] = r.sup_on;
      `HBP_ADDR_STATUS: begin
        d[`HBP_ST_LV] = r.lv;
        d[`HBP_ST_HV] = r.hv;
        d[`HBP_ST_OC] = r.hs_trip | r.ls_trip;
        d[`HBP_ST_HT] = r.ht;
      end
      default: d = `HBP_RST_BYTE;
    endcase
    return d;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    wr_go = 1'b0;
    wdat = {st_r.rx[6:0], mosi_f};
    rise = chopping_frequency_input_f & ~st_r.chopping_frequency_input_d;
    fall = ~chopping_frequency_input_f & st_r.chopping_frequency_input_d;
    en_all = st_r.pstage & ~st_r.lv & ~st_r.hv & ~st_r.therm;

    // pin synchronisers, change taken when stages two and three agree
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.f = (st_r.s2 & st_r.s3) | (st_r.f & (st_r.s2 ^ st_r.s3));
    st_nxt.sck_d = sck_f;
    st_nxt.cs_d = cs_f;
    st_nxt.chopping_frequency_input_d = chopping_frequency_input_f;

    // register port: byte one address, byte two data
    if (cs_f) begin
      st_nxt.st = HBP_SPI_IDLE;
      st_nxt.oe = 1'b0;
    end else if (st_r.cs_d) begin
      st_nxt.st = HBP_SPI_ADDR;
      st_nxt.bitc = '0;
      st_nxt.tx = rd_reg(st_r, `HBP_ADDR_STATUS);
      st_nxt.oe = 1'b1;
    end else begin
      if (sck_f & ~st_r.sck_d &
          ((st_r.st == HBP_SPI_ADDR) || (st_r.st == HBP_SPI_DATA))) begin
        st_nxt.rx = wdat;
        st_nxt.bitc = st_r.bitc + 4'h1;
        if (st_r.bitc == `HBP_BITS_PER_BYTE) begin
          st_nxt.bitc = '0;
          if (st_r.st == HBP_SPI_ADDR) begin
            st_nxt.addr = wdat[`HBP_AW-1:0];
            st_nxt.wr = wdat[`HBP_WR_BIT];
            st_nxt.st = HBP_SPI_DATA;
          end else begin
            wr_go = st_r.wr;
            st_nxt.st = HBP_SPI_DONE;
          end
        end
      end
      if (~sck_f & st_r.sck_d) begin
        if ((st_r.st == HBP_SPI_DATA) && (st_r.bitc == '0)) begin
          st_nxt.tx = rd_reg(st_r, st_r.addr);
        end else begin
          st_nxt.tx = {st_r.tx[6:0], 1'b0};
        end
      end
    end

    // register writes and write-one clears
    if (wr_go) begin
      case (st_r.addr)
        `HBP_ADDR_SWITCHES: st_nxt.sw = wdat;
        `HBP_ADDR_CTRL: st_nxt.ctrl = wdat & `HBP_CTRL_MASK;
        `HBP_ADDR_SYS: st_nxt.pstage = wdat[`HBP_BIT_PSTAGE];
        `HBP_ADDR_FLAGS: begin
          if (wdat[`HBP_FLG_HT]) st_nxt.ht = 1'b0;
          if (wdat[`HBP_FLG_LV]) st_nxt.lv = 1'b0;
          if (wdat[`HBP_FLG_HV]) st_nxt.hv = 1'b0;
        end
        `HBP_ADDR_RSTMASK: st_nxt.htre = wdat[`HBP_BIT_HTRE];
        `HBP_ADDR_SUPPLY: st_nxt.sup_on = wdat[`HBP_BIT_SUP_ON];
        `HBP_ADDR_STATUS: begin
          if (wdat[`HBP_ST_OC]) begin
            st_nxt.hs_trip = 1'b0;
            st_nxt.ls_trip = 1'b0;
          end
        end
        default: st_nxt.sw = st_r.sw;
      endcase
    end

    // fault flags: a pending event wins over a clear
    if (ht_f) st_nxt.ht = 1'b1;
    if (lv_f) st_nxt.lv = 1'b1;
    if (hv_f) st_nxt.hv = 1'b1;
    if (hsoc_f) st_nxt.hs_trip = 1'b1;
    if (lsoc_f) st_nxt.ls_trip = 1'b1;
    if (st_r.htre & tl_f) st_nxt.therm = 1'b1;

    // bridge requests, supply and status outputs
    st_nxt.req_hs = {4{en_all & ~st_r.hs_trip}} &
      {st_r.sw[7], st_r.sw[5], st_r.sw[3], st_r.sw[1]};
    st_nxt.req_ls = {4{en_all & ~st_r.ls_trip}} &
      {st_r.sw[6], st_r.sw[4], st_r.sw[2], st_r.sw[0]};
    st_nxt.sup_pin = st_r.pstage & st_r.sup_on & ~st_r.therm;
    st_nxt.recirc = |rc_f;
    st_nxt.lim_en = st_r.ctrl[`HBP_LIM_HI:0] >= `HBP_LIM_MIN;
    st_nxt.rearm_lo = rise;
    st_nxt.rearm_hi = st_r.ctrl[`HBP_BIT_OFC] ? fall : rise;
  end

  // reset clears every register and flag
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // half-bridge drivers
  hbp_chan_if ch[4] ();

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_br
      assign ch[g].req_hs = st_r.req_hs[g];
      assign ch[g].req_ls = st_r.req_ls[g];
      assign ch[g].rearm = (g < 2) ? st_r.rearm_lo : st_r.rearm_hi;
      assign ch[g].lim_en = st_r.lim_en;
      assign ch[g].over_lim = lim_f[g];
      assign high_side_on_out[g] = ch[g].hs_on;
      assign low_side_on_out[g] = ch[g].ls_on;
      hbp_bridge u_br (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ch(ch[g].drv)
      );
    end
  endgenerate

  // ==========================================
  // outputs
  assign spi_miso_out = st_r.tx[7];
  assign spi_miso_oe_out = st_r.oe;
  assign switched_supply_pin_out = st_r.sup_pin;
  assign recirculation_detect_out = st_r.recirc;
  assign sense_gain_select_out = st_r.ctrl[`HBP_BIT_GAIN];
  assign current_limit_select_out = st_r.ctrl[`HBP_LIM_HI:0];
  assign limit_active_out = st_r.lim_en;
  assign reset_request_out = st_r.therm;

endmodule

// [hbp_chop_host.sv]
`timescale 1ns/100ps
module hbp_chop_host #(
  parameter int HALF = 625
) (
  input wire logic core_clk_in,
  input wire logic run_in,
  output logic chop_out
);
  logic [15:0] cnt_r = 16'h0000;
  logic chop_r = 1'b0;
  // ==========================================
  // chopping clock from the host, stands low while stopped
  always_ff @(posedge core_clk_in) begin
    if (!run_in) begin
      cnt_r <= 16'h0000;
      chop_r <= 1'b0;
    end else if (cnt_r == 16'(HALF - 1)) begin
      cnt_r <= 16'h0000;
      chop_r <= ~chop_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign chop_out = chop_r;
endmodule

// [hbp_props.sv]
`timescale 1ns/100ps
module hbp_props (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic hs_overcurrent_in,
  input wire logic ls_overcurrent_in,
  input wire logic [3:0] recirc_sense_in,
  input wire logic voltage_low_in,
  input wire logic [3:0] high_side_on_out,
  input wire logic [3:0] low_side_on_out,
  input wire logic switched_supply_pin_out,
  input wire logic recirculation_detect_out,
  input wire logic [2:0] current_limit_select_out,
  input wire logic limit_active_out,
  input wire logic reset_request_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // gate protection
  a_no_shoot: assert property ((high_side_on_out & low_side_on_out) == 4'h0)
    else $error("both fets of a bridge on");
  a_break_gap: assert property ($fell(high_side_on_out[0]) |-> !low_side_on_out[0] [*4])
    else $error("low side on without break interval");
  a_hs_trip: assert property (hs_overcurrent_in [*8] |=> high_side_on_out == 4'h0)
    else $error("high sides on during overcurrent");
  a_ls_trip: assert property (ls_overcurrent_in [*8] |=> low_side_on_out == 4'h0)
    else $error("low sides on during overcurrent");
  a_volt_off: assert property (voltage_low_in [*8] |=> (high_side_on_out | low_side_on_out) == 4'h0)
    else $error("bridges on during low voltage");
  a_recirc_on: assert property ((recirc_sense_in != 4'h0) [*8] |=> recirculation_detect_out)
    else $error("recirculation not flagged");
  a_lim_decode: assert property ($stable(current_limit_select_out) [*3] |->
    limit_active_out == (current_limit_select_out >= 3'h3))
    else $error("limit decode wrong");
  a_therm_hold: assert property (reset_request_out |=> reset_request_out)
    else $error("thermal request dropped");
  a_therm_off: assert property (reset_request_out [*4] |->
    (high_side_on_out | low_side_on_out) == 4'h0 && !switched_supply_pin_out)
    else $error("outputs on after thermal trip");
  a_reset_clear: assert property ($fell(rst_in) |-> high_side_on_out == 4'h0
    && low_side_on_out == 4'h0 && !switched_supply_pin_out)
    else $error("outputs on after reset");
  c_hs: cover property (high_side_on_out == 4'hF);
  c_ls: cover property (low_side_on_out == 4'hF);
  c_therm: cover property (reset_request_out);
endmodule
bind hbp_stage_ctrl hbp_props props_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .hs_overcurrent_in(hs_overcurrent_in), .ls_overcurrent_in(ls_overcurrent_in),
  .recirc_sense_in(recirc_sense_in), .voltage_low_in(voltage_low_in),
  .high_side_on_out(high_side_on_out), .low_side_on_out(low_side_on_out),
  .switched_supply_pin_out(switched_supply_pin_out),
  .recirculation_detect_out(recirculation_detect_out),
  .current_limit_select_out(current_limit_select_out),
  .limit_active_out(limit_active_out), .reset_request_out(reset_request_out));

// [tb.sv]
`timescale 1ns/100ps
`include "hbp_defs.svh"
module tb;
  localparam int HALF = 625;
  localparam logic [5:0] SW = `HBP_ADDR_SWITCHES;
  localparam logic [5:0] CT = `HBP_ADDR_CTRL;
  localparam logic [5:0] SP = `HBP_ADDR_SUPPLY;
  localparam logic [5:0] ST = `HBP_ADDR_STATUS;
  logic clk = 1'b0, rst_in = 1'b1, sck = 1'b0, csn = 1'b1, mosi = 1'b0, run = 1'b0;
  logic hoc = 1'b0, loc = 1'b0, vlo = 1'b0, tlim = 1'b0, vhi = 1'b0, twarn = 1'b0;
  logic oe_mid = 1'b0;
  logic [3:0] lim = 4'h0, rec = 4'h0, hs, ls;
  logic miso, oe, chop, sup, recirculation_detect, gain, la, rreq;
  logic [2:0] cls;
  logic [15:0] rx;
  int n_fail = 0, n_checks = 0, cyc_n = 0;
  hbp_chop_host #(.HALF(HALF)) host_u (.core_clk_in(clk), .run_in(run), .chop_out(chop));
  hbp_stage_ctrl dut_u (.core_clk_in(clk), .rst_in(rst_in), .spi_sck_in(sck),
    .spi_cs_n_in(csn), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe),
    .chopping_frequency_input_in(chop), .hs_overcurrent_in(hoc), .ls_overcurrent_in(loc),
    .ls_over_limit_in(lim), .recirc_sense_in(rec), .voltage_low_in(vlo),
    .voltage_high_in(vhi), .temp_warn_in(twarn), .temp_limit_in(tlim),
    .high_side_on_out(hs), .low_side_on_out(ls), .switched_supply_pin_out(sup),
    .recirculation_detect_out(recirculation_detect), .sense_gain_select_out(gain),
    .current_limit_select_out(cls), .limit_active_out(la), .reset_request_out(rreq));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] sh;
    sh = {a, d};
    csn <= 1'b0;
    cyc(8);
    for (int i = 15; i >= 0; i--) begin
      mosi <= sh[i];
      cyc(7);
      rx = {rx[14:0], miso};
      if (i == 15) oe_mid = oe;
      sck <= 1'b1;
      cyc(7);
      sck <= 1'b0;
    end
    cyc(8);
    csn <= 1'b1;
    cyc(8);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer({2'b10, a}, d);
    cyc(20);
  endtask
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    xfer({2'b00, a}, 8'h00);
    chk(nm, rx[7:0], e);
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      n_fail++;
      close_out();
    end
  end
  // ==========================================
  // tests
  initial begin
    cyc(10);
    rst_in <= 1'b0;
    cyc(8);
    chk("oe", {7'h0, oe}, 8'h00);
    rdchk("switches", SW, 8'h00);
    chk("oe", {7'h0, oe_mid}, 8'h01);
    rdchk("ctrl", CT, 8'h00);
    rdchk("supply", SP, 8'h00);
    rdchk("system_control", `HBP_ADDR_SYS, 8'h00);
    wr(CT, 8'hFF);
    rdchk("ctrl", CT, 8'hC7);
    chk("gain", {7'h0, gain}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(CT, 8'(i));
      chk("limit", {7'h0, la}, {7'h0, i >= 3});
      chk("cls", {5'h0, cls}, 8'(i));
    end
    chk("gain", {7'h0, gain}, 8'h00);
    wr(SW, 8'h55);
    chk("ls", {4'h0, ls}, 8'h00);
    wr(`HBP_ADDR_SYS, 8'h80);
    chk("ls", {4'h0, ls}, 8'h0F);
    wr(SW, 8'hAA);
    chk("hs", {hs, ls}, 8'hF0);
    wr(SW, 8'hFF);
    chk("hs", {hs, ls}, 8'hF0);
    wr(SP, 8'h02);
    chk("sup", {7'h0, sup}, 8'h01);
    vlo <= 1'b1;
    vhi <= 1'b1;
    cyc(20);
    chk("hs", {4'h0, hs}, 8'h00);
    chk("sup", {7'h0, sup}, 8'h01);
    rdchk("status", ST, 8'h0C);
    wr(`HBP_ADDR_FLAGS, 8'h0C);
    chk("hs", {4'h0, hs}, 8'h00);
    vlo <= 1'b0;
    vhi <= 1'b0;
    wr(`HBP_ADDR_FLAGS, 8'h08);
    chk("hs", {4'h0, hs}, 8'h00);
    wr(`HBP_ADDR_FLAGS, 8'h04);
    chk("hs", {4'h0, hs}, 8'h0F);
    hoc <= 1'b1;
    cyc(20);
    hoc <= 1'b0;
    chk("hs", {4'h0, hs}, 8'h00);
    rdchk("status", ST, 8'h02);
    wr(ST, 8'h02);
    chk("hs", {4'h0, hs}, 8'h0F);
    wr(SW, 8'h55);
    loc <= 1'b1;
    cyc(20);
    loc <= 1'b0;
    chk("ls", {4'h0, ls}, 8'h00);
    wr(ST, 8'h02);
    chk("ls", {4'h0, ls}, 8'h0F);
    lim <= 4'h1;
    cyc(20);
    lim <= 4'h0;
    cyc(20);
    chk("ls", {4'h0, ls}, 8'h0E);
    run <= 1'b1;
    cyc(HALF + 20);
    chk("ls", {4'h0, ls}, 8'h0F);
    run <= 1'b0;
    wr(CT, 8'h87);
    lim <= 4'hF;
    cyc(20);
    lim <= 4'h0;
    run <= 1'b1;
    cyc(HALF + 20);
    chk("ls", {4'h0, ls}, 8'h03);
    cyc(HALF);
    chk("ls", {4'h0, ls}, 8'h0F);
    run <= 1'b0;
    rec <= 4'h4;
    cyc(10);
    chk("recirculation_detect", {7'h0, recirculation_detect}, 8'h01);
    rec <= 4'h0;
    twarn <= 1'b1;
    cyc(10);
    twarn <= 1'b0;
    chk("recirculation_detect", {7'h0, recirculation_detect}, 8'h00);
    rdchk("status", ST, 8'h01);
    wr(`HBP_ADDR_FLAGS, 8'h10);
    rdchk("status", ST, 8'h00);
    wr(`HBP_ADDR_RSTMASK, 8'h01);
    tlim <= 1'b1;
    cyc(20);
    chk("rreq", {7'h0, rreq}, 8'h01);
    chk("sup", {3'h0, sup, ls}, 8'h00);
    tlim <= 1'b0;
    rst_in <= 1'b1;
    cyc(3);
    rst_in <= 1'b0;
    cyc(8);
    rdchk("switches", SW, 8'h00);
    close_out();
  end
endmodule
